// [src/sps_consts.svh]
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH

// Core clock rate
`define SPS_CLK_MHZ          25
// Soft-start interval in microseconds
`define SPS_SS_TIME_US       3500
// Brown-out persistence in milliseconds
`define SPS_BO_TIME_MS       32
// Length of one measurement phase in microseconds
`define SPS_MEAS_PHASE_US    100
`define SPS_MEAS_PHASE_CYC   (`SPS_MEAS_PHASE_US * `SPS_CLK_MHZ)
`define SPS_PHASE_CNT_W      12

// Soft-start ramp: 8-bit limit, 256 steps
`define SPS_SS_LIMIT_W       8
`define SPS_SS_STEPS         256
`define SPS_SS_DIV_W         12
`define SPS_BO_CNT_W         20

// Consecutive counts
`define SPS_OT_COUNT         3'h4
`define SPS_MAXDUTY_COUNT    4'h8

// Mains current code width and levels
`define SPS_MAINS_W          8
`define SPS_BROWNIN_LEVEL    8'h40
`define SPS_BROWNOUT_LEVEL   8'h30

`endif

// [src/sps_pkg.sv]
package sps_pkg;

   typedef enum logic [2:0] {
      ST_OFF,
      ST_CHECK,
      ST_RUN,
      ST_DISCHARGE,
      ST_PWRDN,
      ST_LATCHED
   } sps_state_t;

   // Asynchronous level inputs from the power stage and sensing network
   typedef struct packed {
      logic supply_startup;
      logic supply_lockout;
      logic prot_above_det;
      logic overpower;
      logic ovp_internal;
      logic ovp_external;
      logic otp_internal;
   } sps_pins_t;

   // Sequencer status towards the rest of the controller
   typedef struct packed {
      logic power_down;
      logic supply_clamp;
      logic latched;
      logic brownout_flag;
      logic temp_phase;
   } sps_status_t;

endpackage

// [src/sps_meas_timer.sv]
`timescale 1ns/1ns
`include "sps_consts.svh"

module sps_meas_timer (
   input  wire logic core_clk_in,    // 25 MHz core clock
   input  wire logic reset_in,       // Async reset, active high
   output logic      temp_phase_out, // 0 mains phase, 1 temperature phase
   output logic      phase_end_out   // Pulse on last cycle of a phase
);
   localparam logic [`SPS_PHASE_CNT_W-1:0] LAST =
      `SPS_PHASE_CNT_W'(`SPS_MEAS_PHASE_CYC - 1);

   logic [`SPS_PHASE_CNT_W-1:0] cnt;

   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         cnt            <= '0;
         temp_phase_out <= 1'b0;
      end else if (cnt == LAST) begin
         cnt            <= '0;
         temp_phase_out <= ~temp_phase_out;
      end else begin
         cnt            <= cnt + 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         phase_end_out <= 1'b0;
      end else begin
         phase_end_out <= (cnt == LAST - 1'b1);
      end
   end

   a_phase_toggle: assert property (@(posedge core_clk_in) disable iff (reset_in)
      phase_end_out |=> (temp_phase_out != $past(temp_phase_out)))
      else $error("phase did not alternate after phase end");

endmodule

// [src/sps_sequencer.sv]
// Behaviour
// - At start-up level, switch only if mains and temp pass
// - Ramp peak current limit over 3.5 ms
// - Any protection stops gate drive immediately
// - Brown-out and max duty are restart class
// - Overpower, lockout, OVERVOLTAGE_PROTECTION, OTP are latch class
// - Restart: off until lockout, power-down, recharge, resume
// - Latch: power-down at once, enable supply clamp
// - Lockout during run takes the latched path
// - Alternate mains and temperature measurement phases
// - Capture mains current in each mains phase
// - Permit switching when stored current exceeds brown-in
// - Brown-out after 32 ms below level, restart
// - Four low temperature samples trip latched overtemperature
// - Stored mains current feeds compensation and limits
// - Eight consecutive max-duty strokes trigger restart
`timescale 1ns/1ns
`include "sps_consts.svh"

module sps_sequencer #(
   parameter int SS_CYCLES = `SPS_SS_TIME_US * `SPS_CLK_MHZ,
   parameter int BO_CYCLES = `SPS_BO_TIME_MS * 1000 * `SPS_CLK_MHZ
) (
   input  wire logic                        core_clk_in,          // 25 MHz core clock
   input  wire logic                        reset_in,             // Supply reset, async
   input  wire sps_pkg::sps_pins_t          pins_in,              // Async comparator levels
   input  wire logic [`SPS_MAINS_W-1:0]     mains_current_in,     // Async mains current code
   input  wire logic                        stroke_end_in,        // Stroke end pulse, core clk
   input  wire logic                        stroke_maxduty_in,    // Stroke hit max duty
   output logic                             gate_enable_out,      // Gate drive permitted
   output logic [`SPS_SS_LIMIT_W-1:0]       softstart_limit_out,  // Peak current limit
   output logic [`SPS_MAINS_W-1:0]          mains_hold_out,       // Stored mains current
   output sps_pkg::sps_status_t             status_out            // Sequencer status
);
   import sps_pkg::*;

   localparam int SS_STEP_INT = (SS_CYCLES + `SPS_SS_STEPS - 1) / `SPS_SS_STEPS;
   localparam logic [`SPS_SS_DIV_W-1:0] SS_STEP = `SPS_SS_DIV_W'(SS_STEP_INT - 1);
   localparam logic [`SPS_BO_CNT_W-1:0] BO_LAST = `SPS_BO_CNT_W'(BO_CYCLES - 1);

   sps_pins_t                   pins_meta;
   sps_pins_t                   pins;
   logic [`SPS_MAINS_W-1:0]     mains_meta;
   logic [`SPS_MAINS_W-1:0]     mains;
   sps_state_t                  state;
   sps_state_t                  next_state;
   logic                        temp_phase;
   logic                        phase_end;
   logic                        mains_seen;
   logic                        temp_seen;
   logic                        temp_ok;
   logic                        permit;
   logic [2:0]                  ot_cnt;
   logic                        ot_trip;
   logic [3:0]                  md_cnt;
   logic                        md_trip;
   logic [`SPS_BO_CNT_W-1:0]    bo_cnt;
   logic                        bo_trip;
   logic [`SPS_SS_DIV_W-1:0]    ss_div;
   logic                        latch_evt;
   logic                        restart_evt;

   // Two-flop synchronisers for everything from the pins
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         pins_meta  <= '0;
         pins       <= '0;
         mains_meta <= '0;
         mains      <= '0;
      end else begin
         pins_meta  <= pins_in;
         pins       <= pins_meta;
         mains_meta <= mains_current_in;
         mains      <= mains_meta;
      end
   end

   sps_meas_timer u_meas_timer (
      .core_clk_in    (core_clk_in),
      .reset_in       (reset_in),
      .temp_phase_out (temp_phase),
      .phase_end_out  (phase_end)
   );

   // Mains capture and brown-in permit
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         mains_hold_out <= '0;
         permit         <= 1'b0;
      end else begin
         if (phase_end && !temp_phase) begin
            mains_hold_out <= mains;
         end
         permit <= (mains_hold_out > `SPS_BROWNIN_LEVEL);
      end
   end

   // Fresh samples required for each start-up check
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         mains_seen <= 1'b0;
         temp_seen  <= 1'b0;
         temp_ok    <= 1'b0;
      end else begin
         if (state != ST_CHECK) begin
            mains_seen <= 1'b0;
            temp_seen  <= 1'b0;
         end else if (phase_end) begin
            if (temp_phase) begin
               temp_seen <= 1'b1;
            end else begin
               mains_seen <= 1'b1;
            end
         end
         if (phase_end && temp_phase) begin
            temp_ok <= pins.prot_above_det;
         end
      end
   end

   // Consecutive overtemperature samples
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         ot_cnt  <= '0;
         ot_trip <= 1'b0;
      end else if (phase_end && temp_phase) begin
         if (pins.prot_above_det) begin
            ot_cnt <= '0;
         end else if (ot_cnt + 1'b1 == `SPS_OT_COUNT) begin
            ot_cnt  <= '0;
            ot_trip <= 1'b1;
         end else begin
            ot_cnt <= ot_cnt + 1'b1;
         end
      end else begin
         ot_trip <= 1'b0;
      end
   end

   // Consecutive max-duty strokes
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         md_cnt  <= '0;
         md_trip <= 1'b0;
      end else if (state != ST_RUN) begin
         md_cnt  <= '0;
         md_trip <= 1'b0;
      end else if (stroke_end_in) begin
         if (!stroke_maxduty_in) begin
            md_cnt <= '0;
         end else if (md_cnt + 1'b1 == `SPS_MAXDUTY_COUNT) begin
            md_cnt  <= '0;
            md_trip <= 1'b1;
         end else begin
            md_cnt <= md_cnt + 1'b1;
         end
      end else begin
         md_trip <= 1'b0;
      end
   end

   // Brown-out persistence timer
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         bo_cnt  <= '0;
         bo_trip <= 1'b0;
      end else if (state != ST_RUN || mains_hold_out >= `SPS_BROWNOUT_LEVEL) begin
         bo_cnt  <= '0;
         bo_trip <= 1'b0;
      end else if (bo_cnt == BO_LAST) begin
         bo_trip <= 1'b1;
      end else begin
         bo_cnt <= bo_cnt + 1'b1;
      end
   end

   always_comb begin
      latch_evt = pins.overpower | pins.ovp_internal | pins.ovp_external
                | pins.otp_internal | ot_trip | pins.supply_lockout;
      // Brown-in permit gates start only; loss in run goes through brown-out timer
      restart_evt = bo_trip | md_trip;
   end

   always_comb begin
      next_state = state;
      unique case (state)
         ST_OFF: begin
            if (pins.supply_startup) begin
               next_state = ST_CHECK;
            end
         end
         ST_CHECK: begin
            if (latch_evt && !pins.supply_lockout) begin
               next_state = ST_LATCHED;
            end else if (pins.supply_lockout) begin
               next_state = ST_PWRDN;
            end else if (mains_seen && temp_seen && permit && temp_ok) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (latch_evt) begin
               next_state = ST_LATCHED;
            end else if (restart_evt) begin
               next_state = ST_DISCHARGE;
            end
         end
         ST_DISCHARGE: begin
            if (pins.supply_lockout) begin
               next_state = ST_PWRDN;
            end
         end
         ST_PWRDN: begin
            if (pins.supply_startup && !pins.supply_lockout) begin
               next_state = ST_CHECK;
            end
         end
         ST_LATCHED: begin
            next_state = ST_LATCHED;
         end
      endcase
   end

   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         state <= ST_OFF;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         gate_enable_out <= 1'b0;
         status_out      <= '0;
      end else begin
         gate_enable_out         <= (next_state == ST_RUN);
         status_out.power_down   <= (next_state == ST_PWRDN) || (next_state == ST_LATCHED);
         status_out.supply_clamp <= (next_state == ST_LATCHED);
         status_out.latched      <= (next_state == ST_LATCHED);
         status_out.temp_phase   <= temp_phase;
         if (bo_trip && state == ST_RUN) begin
            status_out.brownout_flag <= 1'b1;
         end else if (next_state == ST_RUN && state != ST_RUN) begin
            status_out.brownout_flag <= 1'b0;
         end
      end
   end

   // Soft-start ramp of the peak current limit
   always_ff @(posedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         ss_div              <= '0;
         softstart_limit_out <= '0;
      end else if (state != ST_RUN) begin
         ss_div              <= '0;
         softstart_limit_out <= '0;
      end else if (softstart_limit_out != '1) begin
         if (ss_div == SS_STEP) begin
            ss_div              <= '0;
            softstart_limit_out <= softstart_limit_out + 1'b1;
         end else begin
            ss_div <= ss_div + 1'b1;
         end
      end
   end

   a_latch_sticky: assert property (@(posedge core_clk_in) disable iff (reset_in)
      status_out.latched |=> status_out.latched && !gate_enable_out)
      else $error("latched state left or gate enabled");

   a_gate_stop: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state == ST_RUN && (latch_evt || restart_evt)) |=> !gate_enable_out)
      else $error("gate not stopped on protection");

   a_clamp_latch: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state == ST_RUN && latch_evt) |=> status_out.supply_clamp && status_out.power_down)
      else $error("latch event without clamp and power-down");

   a_lockout_latch: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state == ST_RUN && pins.supply_lockout) |=> state == ST_LATCHED)
      else $error("lockout in run did not latch");

   a_start_permit: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state == ST_CHECK && next_state == ST_RUN) |-> permit && temp_ok)
      else $error("switching started without passing checks");

   a_restart_path: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state == ST_RUN && !latch_evt && (md_trip || bo_trip)) |=>
      state == ST_DISCHARGE ##1 (!gate_enable_out)[*3])
      else $error("restart event not handled as restart");

   a_recharge: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state == ST_DISCHARGE && pins.supply_lockout) |=> status_out.power_down)
      else $error("no power-down at lockout");

   a_mains_store: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (phase_end && !temp_phase) |=> mains_hold_out == $past(mains))
      else $error("mains current not captured");

   a_ot_trip: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (phase_end && temp_phase && !pins.prot_above_det && ot_cnt == 3'h3) |=> ot_trip)
      else $error("fourth low sample did not trip");

   a_ot_clear: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (phase_end && temp_phase && pins.prot_above_det) |=> ot_cnt == 3'h0 && !ot_trip)
      else $error("overtemperature counter not cleared");

   a_md_trip: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state == ST_RUN && stroke_end_in && stroke_maxduty_in && md_cnt == 4'h7) |=> md_trip)
      else $error("eighth max-duty stroke did not trip");

   a_ss_start: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state != ST_RUN && next_state == ST_RUN) |=> softstart_limit_out == '0)
      else $error("soft-start did not begin at zero");

   a_bo_flag: assert property (@(posedge core_clk_in) disable iff (reset_in)
      (state == ST_RUN && bo_trip) |=> status_out.brownout_flag && !gate_enable_out)
      else $error("brown-out not flagged");

endmodule

// [verif/sps_stage_model.sv]
`timescale 1ns/1ns

module sps_stage_model #(
   parameter int VCC_START = 40,
   parameter int VCC_UVLO  = 20
) (
   input  wire logic                 core_clk_in, // Core clock
   input  wire logic                 reset_in,    // Supply reset
   input  wire logic                 gate_en_in,  // Gate drive permit
   input  wire sps_pkg::sps_status_t status_in,   // Sequencer status
   input  wire logic                 sag_in,      // Collapse the supply
   output logic                      startup_out, // Supply at start-up level
   output logic                      lockout_out  // Supply below lockout
);
   import sps_pkg::*;

   int   vcc;
   logic drain;
   logic gate_q;

   // Supply capacitor: charged from mains, drained after switching stops
   always @(negedge core_clk_in or posedge reset_in) begin
      if (reset_in) begin
         vcc = 0;
         drain = 1'b0;
         gate_q = 1'b0;
      end else begin
         if (gate_q && !gate_en_in) begin
            drain = 1'b1;
         end
         if (status_in.power_down) begin
            drain = 1'b0;
         end
         gate_q = gate_en_in;
         if (sag_in) begin
            vcc = 0;
         end else if (status_in.supply_clamp) begin
            vcc = VCC_UVLO + 1;
         end else if (gate_en_in) begin
            vcc = vcc;
         end else if (drain) begin
            vcc = vcc - 1;
         end else if (vcc < VCC_START) begin
            vcc = vcc + 1;
         end
      end
   end

   assign startup_out = (vcc >= VCC_START);
   assign lockout_out = (vcc < VCC_UVLO);
endmodule

// [verif/smps_protection_sequencer_tb_top.sv]
`timescale 1ns/1ns
`include "sps_consts.svh"

module smps_protection_sequencer_tb_top;
   import sps_pkg::*;

   logic        clk;
   logic        rst;
   logic        prot_ok;
   logic [3:0]  faults;
   logic        sag;
   logic [7:0]  mains;
   logic        stroke;
   logic        maxduty;
   logic        v_start;
   logic        v_low;
   logic        gate;
   logic [7:0]  limit;
   logic [7:0]  hold;
   sps_status_t st;
   sps_pins_t   pins;
   int          miscompares = 0;
   int          tests_run = 0;
   logic [7:0]  exp_q[$];
   int          ot_cnt;
   int          len;
   logic [7:0]  pat = 8'h08;

   assign pins = {v_start, v_low, prot_ok, faults};

   sps_sequencer #(.SS_CYCLES(512), .BO_CYCLES(200)) i_dut (
      .core_clk_in         (clk),
      .reset_in            (rst),
      .pins_in             (pins),
      .mains_current_in    (mains),
      .stroke_end_in       (stroke),
      .stroke_maxduty_in   (maxduty),
      .gate_enable_out     (gate),
      .softstart_limit_out (limit),
      .mains_hold_out      (hold),
      .status_out          (st)
   );

   sps_stage_model i_stage (
      .core_clk_in (clk),
      .reset_in    (rst),
      .gate_en_in  (gate),
      .status_in   (st),
      .sag_in      (sag),
      .startup_out (v_start),
      .lockout_out (v_low)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic sig(input int sel);
      case (sel)
         0: return gate;
         1: return st.power_down;
         default: return st.temp_phase;
      endcase
   endfunction

   // Bounded wait on a design output, then compare
   task automatic wait_bit(input int sel, input logic lvl, input int lim, input string what);
      int n;
      n = 0;
      while (sig(sel) !== lvl && n < lim) begin
         @(negedge clk);
         n++;
      end
      check(what, 16'(sig(sel)), 16'(lvl));
   endtask

   task automatic power_up(input logic [7:0] m);
      rst = 1'b1;
      faults = 4'h0;
      prot_ok = 1'b1;
      sag = 1'b0;
      mains = m;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      wait_bit(0, 1'b1, 9000, "start gate");
   endtask

   task automatic strokes(input int n, input logic md);
      repeat (n) begin
         stroke = 1'b1;
         maxduty = md;
         @(negedge clk);
         stroke = 1'b0;
         repeat (3) @(negedge clk);
      end
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (98000) @(posedge clk);
      miscompares++;
      $display("CHECK FAILED watchdog expected done seen hang");
      finish_test();
   end

   initial begin
      rst = 1'b1;
      prot_ok = 1'b1;
      faults = 4'h0;
      sag = 1'b0;
      mains = 8'h00;
      stroke = 1'b0;
      maxduty = 1'b0;
      void'($urandom(88));
      power_up(8'h41 + 8'($urandom % 190));
      check("hold", hold, mains);
      repeat (200) @(negedge clk);
      check("ss mid", 16'(limit > 8'h50 && limit < 8'h70), 16'h1);
      repeat (400) @(negedge clk);
      check("ss end", limit, 8'hFF);
      $display("test start done");
      strokes(7, 1'b1);
      strokes(1, 1'b0);
      strokes(7, 1'b1);
      check("md seven", gate, 1'b1);
      strokes(1, 1'b1);
      wait_bit(0, 1'b0, 2, "md trip");
      check("md latch", st.latched, 1'b0);
      wait_bit(1, 1'b1, 200, "md pd");
      wait_bit(0, 1'b1, 9000, "md resume");
      $display("test maxduty done");
      mains = 8'($urandom % 8'h30);
      wait_bit(0, 1'b0, 5400, "bo stop");
      check("bo flag", st.brownout_flag, 1'b1);
      check("bo latch", st.latched, 1'b0);
      mains = 8'hC0;
      wait_bit(0, 1'b1, 12000, "bo resume");
      check("bo flag clr", st.brownout_flag, 1'b0);
      $display("test brownout done");
      sag = 1'b1;
      @(negedge clk);
      sag = 1'b0;
      wait_bit(0, 1'b0, 5, "uvlo stop");
      @(negedge clk);
      check("uvlo latch", {st.latched, st.supply_clamp, st.power_down}, 3'h7);
      $display("test lockout done");
      for (int i = 0; i < 4; i++) begin
         power_up(8'hC0);
         faults = 4'h1 << i;
         wait_bit(0, 1'b0, 4, "latch stop");
         @(negedge clk);
         check("latch flags", {st.latched, st.supply_clamp, st.power_down}, 3'h7);
         check("latch limit", limit, 8'h00);
         faults = 4'h0;
         repeat (50) @(negedge clk);
         check("latch stays", gate, 1'b0);
      end
      $display("test latch done");
      power_up(8'hC0);
      wait_bit(2, 1'b1, 6000, "temp rise");
      len = 0;
      while (st.temp_phase === 1'b1 && len < 3000) begin
         @(negedge clk);
         len++;
      end
      check("temp len", 16'(len), 16'(`SPS_MEAS_PHASE_CYC));
      ot_cnt = 0;
      for (int k = 0; k < 8; k++) begin
         exp_q.push_back(8'h41 + 8'($urandom % 190));
         mains = exp_q[$];
         wait_bit(2, 1'b1, 2600, "temp rise");
         check("hold", hold, exp_q.pop_front());
         prot_ok = pat[k];
         ot_cnt = pat[k] ? 0 : ot_cnt + 1;
         wait_bit(2, 1'b0, 2600, "temp fall");
         repeat (5) @(negedge clk);
         check("ot gate", gate, 16'(ot_cnt < 4));
      end
      check("ot latch", st.latched, 1'b1);
      $display("test temperature done");
      finish_test();
   end
endmodule
